// ===== logic/ais_pkg.sv
package ais_pkg;
  // ----------------------------------------------------------------
  // Word timing and widths
  // ----------------------------------------------------------------
  localparam int AIS_SUB_COUNT = 23;
  localparam int AIS_DATA_BITS = 12;
  localparam int AIS_CODE_BITS = 5;
  localparam int AIS_PROG_MAX = 512;
  localparam logic [4:0] AIS_LAST_BIT = 5'h16;
  localparam logic [4:0] AIS_DATA_LAST = 5'h0b;
  localparam logic [4:0] AIS_CODE_COUNT = 5'h1a;

  // ----------------------------------------------------------------
  // Subinstruction bit positions in the latch
  // ----------------------------------------------------------------
  localparam int SUB_ADD_COMPLEX_MULTIPLY = 0;
  localparam int SUB_ADD_REAL_MULTIPLY = 1;
  localparam int SUB_ADD_SUM_DIFF = 2;
  localparam int SUB_SWAP_INTERMEDIATE_REGS = 3;
  localparam int SUB_LOAD_INTER_2 = 4;
  localparam int SUB_LOAD_INTER_3 = 5;
  localparam int SUB_LOAD_INTER_4 = 6;
  localparam int SUB_LOAD_INTER_5 = 7;
  localparam int SUB_LOAD_INTER_6 = 8;
  localparam int SUB_LOAD_INTER_7 = 9;
  localparam int SUB_LOAD_INTER_8 = 10;
  localparam int SUB_LOAD_PREMUL_1 = 11;
  localparam int SUB_LOAD_PREMUL_2 = 12;
  localparam int SUB_LOAD_PREMUL_3 = 13;
  localparam int SUB_LOAD_PREMUL_4 = 14;
  localparam int SUB_LOAD_PREMUL_5 = 15;
  localparam int SUB_LOAD_REFERENCE_REG = 16;
  localparam int SUB_SHIFT_RIGHT_ONE = 17;
  localparam int SUB_LOAD_INPUT_REG = 18;
  localparam int SUB_LOAD_INPUT_ALT = 19;
  localparam int SUB_LOAD_BUFFER_REGS = 20;
  localparam int SUB_LOAD_PREMUL_AND_REF_COMBO = 21;
  localparam int SUB_BUFFER_OUTPUT_OP = 22;

  typedef logic [AIS_SUB_COUNT-1:0] ais_sub_set_t;

  // One program-store word: buffer-output flag and instruction code
  typedef struct packed {
    logic bufferOutput;
    logic [AIS_CODE_BITS-1:0] code;
  } ais_prog_word_t;

  // Broadcast from control unit to every module
  typedef struct packed {
    logic serialBit;
    logic wordTick;
    logic halve;
    logic [4:0] bitIndex;
  } ais_bcast_t;

  typedef enum logic [1:0] {
    AIS_IDLE = 2'b00,
    AIS_RUN = 2'b01,
    AIS_DRAIN = 2'b10
  } ais_state_t;
endpackage

// ===== logic/ais_module.sv
`timescale 1ns/100ps
module ais_module (
  input wire logic clk,
  input wire logic reset_n,
  input ais_pkg::ais_bcast_t bcast,
  input wire logic dataInBit,
  output logic resultBit,
  output logic overflow,
  output ais_pkg::ais_sub_set_t activeSet
);
  import ais_pkg::*;

  typedef logic [AIS_DATA_BITS-1:0] ais_word_t;

  ais_sub_set_t instrShift, next_instrShift;
  ais_sub_set_t instrLatch, next_instrLatch;
  ais_word_t interReal, interImag, inputReg, premulReg, refReg;
  ais_word_t bufReal, bufImag;
  ais_word_t next_interReal, next_interImag, next_inputReg;
  ais_word_t next_premulReg, next_refReg, next_bufReal, next_bufImag;
  logic next_resultBit, next_overflow;
  logic [AIS_DATA_BITS:0] sumExt, diffExt;
  logic serialPhase;

  assign activeSet = instrLatch;
  assign serialPhase = bcast.bitIndex <= AIS_DATA_LAST;
  assign sumExt = {inputReg[AIS_DATA_BITS-1], inputReg}
                + {premulReg[AIS_DATA_BITS-1], premulReg};
  assign diffExt = {inputReg[AIS_DATA_BITS-1], inputReg}
                 - {premulReg[AIS_DATA_BITS-1], premulReg};

  // ----------------------------------------------------------------
  // Instruction shift register and latch
  // ----------------------------------------------------------------
  // Next word shifts in while the latched word drives the datapath
  always_comb begin
    next_instrShift = {bcast.serialBit, instrShift[AIS_SUB_COUNT-1:1]};
    next_instrLatch = instrLatch;
    if (bcast.wordTick) begin
      next_instrLatch = next_instrShift;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      instrShift <= '0;
      instrLatch <= '0;
    end else begin
      instrShift <= next_instrShift;
      instrLatch <= next_instrLatch;
    end
  end

  // ----------------------------------------------------------------
  // Datapath: serial moves during the word, word ops at its end
  // ----------------------------------------------------------------
  // Only bits that hold one enable their paths
  always_comb begin
    next_interReal = interReal;
    next_interImag = interImag;
    next_inputReg = inputReg;
    next_premulReg = premulReg;
    next_refReg = refReg;
    next_bufReal = bufReal;
    next_bufImag = bufImag;
    next_resultBit = 1'b0;
    next_overflow = 1'b0;
    // Bit-serial fill of the input register, LSB first
    if (serialPhase && instrLatch[SUB_LOAD_INPUT_REG]) begin
      next_inputReg = {dataInBit, inputReg[AIS_DATA_BITS-1:1]};
    end
    // Real goes out while imaginary slides into real
    if (serialPhase && instrLatch[SUB_BUFFER_OUTPUT_OP]) begin
      next_resultBit = bufReal[0];
      next_bufReal = {bufImag[0], bufReal[AIS_DATA_BITS-1:1]};
      next_bufImag = {1'b0, bufImag[AIS_DATA_BITS-1:1]};
    end
    if (bcast.wordTick) begin
      if (instrLatch[SUB_ADD_SUM_DIFF]) begin
        next_interReal = sumExt[AIS_DATA_BITS-1:0];
        next_interImag = diffExt[AIS_DATA_BITS-1:0];
        next_overflow = (sumExt[AIS_DATA_BITS] != sumExt[AIS_DATA_BITS-1])
                      || (diffExt[AIS_DATA_BITS] != diffExt[AIS_DATA_BITS-1]);
      end
      if (instrLatch[SUB_ADD_REAL_MULTIPLY]
          || instrLatch[SUB_ADD_COMPLEX_MULTIPLY]) begin
        next_interReal = interReal + refReg;
      end
      if (instrLatch[SUB_SWAP_INTERMEDIATE_REGS]) begin
        next_interReal = interImag;
        next_interImag = interReal;
      end
      if (instrLatch[SUB_LOAD_INTER_2] || instrLatch[SUB_LOAD_INTER_7]) begin
        next_interReal = inputReg;
      end
      if (|instrLatch[SUB_LOAD_PREMUL_5:SUB_LOAD_PREMUL_1]
          || instrLatch[SUB_LOAD_PREMUL_AND_REF_COMBO]) begin
        next_premulReg = inputReg;
      end
      if (instrLatch[SUB_LOAD_REFERENCE_REG]
          || instrLatch[SUB_LOAD_PREMUL_AND_REF_COMBO]) begin
        next_refReg = inputReg;
      end
      if (instrLatch[SUB_LOAD_BUFFER_REGS]) begin
        next_bufReal = interReal;
        next_bufImag = interImag;
      end
      if (instrLatch[SUB_SHIFT_RIGHT_ONE]) begin
        next_interReal = $signed(next_interReal) >>> 1;
      end
    end
    // Broadcast overflow halves intermediate, input and premultiply values once
    if (bcast.halve) begin
      next_interReal = $signed(next_interReal) >>> 1;
      next_interImag = $signed(next_interImag) >>> 1;
      next_inputReg = $signed(next_inputReg) >>> 1;
      next_premulReg = $signed(next_premulReg) >>> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interReal <= '0;
      interImag <= '0;
      inputReg <= '0;
      premulReg <= '0;
      refReg <= '0;
      bufReal <= '0;
      bufImag <= '0;
      resultBit <= 1'b0;
      overflow <= 1'b0;
    end else begin
      interReal <= next_interReal;
      interImag <= next_interImag;
      inputReg <= next_inputReg;
      premulReg <= next_premulReg;
      refReg <= next_refReg;
      bufReal <= next_bufReal;
      bufImag <= next_bufImag;
      resultBit <= next_resultBit;
      overflow <= next_overflow;
    end
  end
endmodule

// ===== logic/ais_sequencer.sv
// Function
// - Modules shift instruction serially into 23 bits
// - Word boundary copies shift register into latch
// - Each latch bit enables one subinstruction
// - Several enabled bits form one instruction
// - Next instruction shifts while current executes
// - Module offers twenty-three basic subinstructions
// - Exchange swaps the intermediate register pair
// - Six-bit word: code plus buffer-output bit
// - Program store holds at most 512 words
// - Decoder expands code into control shift register
// - Program select picks region read sequentially
// - Any module overflow but one raised by the last word is broadcast to all
// - Overflow events before the last word are counted per computation
// - Modules halve data on overflow notice
// - Buffer output shifts results out of module
// - Imaginary buffer moves into real during output
// - Twelve-bit registers, bit-serial, modules in parallel
`timescale 1ns/100ps
module ais_sequencer #(
  parameter int NUM_MODULES = 4,
  parameter int PROG_DEPTH = 512,
  parameter int REGION_WORDS = 64,
  parameter int SELECT_BITS = 3,
  parameter int OVF_COUNT_BITS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic progWriteEn,
  input wire logic [$clog2(PROG_DEPTH)-1:0] progWriteAddr,
  input ais_pkg::ais_prog_word_t progWriteData,
  input wire logic [SELECT_BITS-1:0] progSelect,
  input wire logic start,
  input wire logic [NUM_MODULES-1:0] dataInBits,
  output logic [NUM_MODULES-1:0] resultBits,
  output logic busy,
  output logic done,
  output logic [OVF_COUNT_BITS-1:0] overflowCount,
  output ais_pkg::ais_sub_set_t currentSet
);
  import ais_pkg::*;

  localparam int ADDR_BITS = $clog2(PROG_DEPTH);
  typedef logic [ADDR_BITS-1:0] ais_addr_t;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Store beyond 512 words is refused before anything runs
  if (PROG_DEPTH > AIS_PROG_MAX || PROG_DEPTH < 2) begin
    $error("program store depth out of range");
  end
  if (REGION_WORDS < 1 ||
      REGION_WORDS * (2 ** SELECT_BITS) > PROG_DEPTH) begin
    $error("regions do not fit the program store");
  end
  if (NUM_MODULES < 1) begin
    $error("at least one module is needed");
  end

  // ----------------------------------------------------------------
  // Decoder: five-bit code to subinstruction set
  // ----------------------------------------------------------------
  function automatic ais_sub_set_t ais_decode(input ais_prog_word_t w);
    ais_sub_set_t s;
    s = '0;
    case (w.code)
      5'h01: begin s[SUB_ADD_COMPLEX_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_2] = 1'b1; end
      5'h02: begin s[SUB_ADD_COMPLEX_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_2] = 1'b1; s[SUB_LOAD_PREMUL_3] = 1'b1;
        s[SUB_SHIFT_RIGHT_ONE] = 1'b1; end
      5'h03: s[SUB_SWAP_INTERMEDIATE_REGS] = 1'b1;
      5'h04: begin s[SUB_ADD_COMPLEX_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_2] = 1'b1; s[SUB_SHIFT_RIGHT_ONE] = 1'b1; end
      5'h05: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_INTER_5] = 1'b1; s[SUB_LOAD_PREMUL_1] = 1'b1; end
      5'h06: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_PREMUL_2] = 1'b1; end
      5'h07: begin s[SUB_LOAD_INTER_7] = 1'b1;
        s[SUB_LOAD_INPUT_REG] = 1'b1; end
      5'h08: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_BUFFER_REGS] = 1'b1; end
      5'h09: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_INTER_6] = 1'b1; s[SUB_LOAD_INTER_5] = 1'b1; end
      5'h0a: s[SUB_LOAD_INTER_7] = 1'b1;
      5'h0b: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_INPUT_REG] = 1'b1; s[SUB_LOAD_BUFFER_REGS] = 1'b1; end
      5'h0c: begin s[SUB_ADD_REAL_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_3] = 1'b1; end
      5'h0d: begin s[SUB_ADD_REAL_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_4] = 1'b1; s[SUB_SHIFT_RIGHT_ONE] = 1'b1; end
      5'h0e: begin s[SUB_ADD_REAL_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_3] = 1'b1; s[SUB_SHIFT_RIGHT_ONE] = 1'b1; end
      5'h0f: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_INTER_4] = 1'b1; s[SUB_LOAD_INTER_8] = 1'b1; end
      5'h10: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_PREMUL_5] = 1'b1; end
      5'h11: s[SUB_ADD_SUM_DIFF] = 1'b1;
      5'h12: begin s[SUB_ADD_COMPLEX_MULTIPLY] = 1'b1;
        s[SUB_LOAD_INTER_2] = 1'b1; s[SUB_LOAD_PREMUL_4] = 1'b1;
        s[SUB_SHIFT_RIGHT_ONE] = 1'b1; end
      5'h13: begin s[SUB_LOAD_PREMUL_1] = 1'b1;
        s[SUB_LOAD_REFERENCE_REG] = 1'b1; end
      5'h14: s[SUB_LOAD_REFERENCE_REG] = 1'b1;
      5'h15: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_INPUT_ALT] = 1'b1; end
      5'h16: begin s[SUB_ADD_SUM_DIFF] = 1'b1;
        s[SUB_LOAD_INTER_4] = 1'b1; end
      5'h17: begin s[SUB_LOAD_REFERENCE_REG] = 1'b1;
        s[SUB_LOAD_INPUT_REG] = 1'b1; end
      5'h18: s[SUB_LOAD_INPUT_REG] = 1'b1;
      5'h19: s[SUB_LOAD_PREMUL_2] = 1'b1;
      AIS_CODE_COUNT: s[SUB_LOAD_PREMUL_AND_REF_COMBO] = 1'b1;
      default: s = '0;
    endcase
    // Buffer output rides on its own bit, never in a code
    s[SUB_BUFFER_OUTPUT_OP] = w.bufferOutput;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Program store, flip-flops loaded through the write port
  // ----------------------------------------------------------------
  ais_prog_word_t progStore [PROG_DEPTH];

  always_ff @(posedge clk) begin
    if (progWriteEn) begin
      progStore[progWriteAddr] <= progWriteData;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  ais_state_t state, next_state;
  ais_addr_t pc, next_pc, regionLast, next_regionLast, regionBase;
  ais_sub_set_t cmdShift, next_cmdShift;
  logic [4:0] bitIndex, next_bitIndex;
  logic next_done, wordTick;
  logic ovfPending, next_ovfPending, halve, next_halve;
  logic [OVF_COUNT_BITS-1:0] next_overflowCount;
  logic [NUM_MODULES-1:0] moduleOvf;
  ais_sub_set_t moduleSets [NUM_MODULES];
  ais_bcast_t bcast;

  assign regionBase = ADDR_BITS'(progSelect * REGION_WORDS);
  assign wordTick = (state != AIS_IDLE) && (bitIndex == AIS_LAST_BIT);
  assign busy = state != AIS_IDLE;
  assign currentSet = moduleSets[0];
  assign bcast = '{serialBit: cmdShift[0], wordTick: wordTick,
                   halve: halve, bitIndex: bitIndex};

  // One word per word time; a drain word lets the last one execute
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_regionLast = regionLast;
    next_cmdShift = cmdShift;
    next_bitIndex = bitIndex;
    next_done = 1'b0;
    case (state)
      AIS_IDLE: begin
        if (start) begin
          next_state = AIS_RUN;
          next_pc = regionBase;
          next_regionLast = ADDR_BITS'(regionBase + REGION_WORDS - 1);
          next_cmdShift = ais_decode(progStore[regionBase]);
          next_bitIndex = '0;
        end
      end
      AIS_RUN, AIS_DRAIN: begin
        next_cmdShift = {1'b0, cmdShift[AIS_SUB_COUNT-1:1]};
        next_bitIndex = bitIndex + 5'h01;
        if (wordTick) begin
          next_bitIndex = '0;
          if (state == AIS_DRAIN) begin
            next_state = AIS_IDLE;
            next_done = 1'b1;
          end else if (pc == regionLast) begin
            next_state = AIS_DRAIN;
          end else begin
            next_pc = pc + 1'b1;
            next_cmdShift = ais_decode(progStore[next_pc]);
          end
        end
      end
      default: next_state = AIS_IDLE;
    endcase
  end

  // Overflow collected all word, broadcast and counted at its end
  always_comb begin
    next_ovfPending = ovfPending | (|moduleOvf);
    next_halve = 1'b0;
    next_overflowCount = overflowCount;
    if (state == AIS_IDLE && start) begin
      next_ovfPending = 1'b0;
      next_overflowCount = '0;
    end else if (wordTick && ovfPending) begin
      next_halve = 1'b1;
      next_ovfPending = |moduleOvf; // new event wins over the clear
      next_overflowCount = overflowCount + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= AIS_IDLE;
      pc <= '0;
      regionLast <= '0;
      cmdShift <= '0;
      bitIndex <= '0;
      done <= 1'b0;
      ovfPending <= 1'b0;
      halve <= 1'b0;
      overflowCount <= '0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      regionLast <= next_regionLast;
      cmdShift <= next_cmdShift;
      bitIndex <= next_bitIndex;
      done <= next_done;
      ovfPending <= next_ovfPending;
      halve <= next_halve;
      overflowCount <= next_overflowCount;
    end
  end

  // ----------------------------------------------------------------
  // Module array, all fed the same broadcast
  // ----------------------------------------------------------------
  for (genvar m = 0; m < NUM_MODULES; m++) begin : gen_mod
    ais_module u_module (
      .clk(clk),
      .reset_n(reset_n),
      .bcast(bcast),
      .dataInBit(dataInBits[m]),
      .resultBit(resultBits[m]),
      .overflow(moduleOvf[m]),
      .activeSet(moduleSets[m])
    );
  end
endmodule

// ===== tb/ais_sequencer_asserts.sv
`timescale 1ns/100ps
module ais_sequencer_asserts #(
  parameter int NUM_MODULES = 4,
  parameter int PROG_DEPTH = 512,
  parameter int REGION_WORDS = 64,
  parameter int SELECT_BITS = 3,
  parameter int OVF_COUNT_BITS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic progWriteEn,
  input wire logic [$clog2(PROG_DEPTH)-1:0] progWriteAddr,
  input ais_pkg::ais_prog_word_t progWriteData,
  input wire logic [SELECT_BITS-1:0] progSelect,
  input wire logic start,
  input wire logic [NUM_MODULES-1:0] dataInBits,
  input wire logic [NUM_MODULES-1:0] resultBits,
  input wire logic busy,
  input wire logic done,
  input wire logic [OVF_COUNT_BITS-1:0] overflowCount,
  input ais_pkg::ais_sub_set_t currentSet
);
  import ais_pkg::*;
  // ------------------------------------------------------------
  // Word-time and run counters
  // ------------------------------------------------------------
  logic accept;
  int wordCnt;
  int next_wordCnt;
  int runCnt;
  int next_runCnt;
  assign accept = start && !busy;
  // Counts restart on an accepted start; runCnt saturates to stay small
  always_comb begin
    next_wordCnt = wordCnt;
    next_runCnt = runCnt;
    if (accept) begin
      next_wordCnt = 1;
      next_runCnt = 1;
    end else begin
      if (wordCnt == 23) begin
        next_wordCnt = 1;
      end else if (wordCnt != 0) begin
        next_wordCnt = wordCnt + 1;
      end
      if (busy && runCnt < 100000) begin
        next_runCnt = runCnt + 1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wordCnt <= 0;
      runCnt <= 0;
    end else begin
      wordCnt <= next_wordCnt;
      runCnt <= next_runCnt;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_reset_clears: assert property (
    @(posedge clk)
    !reset_n |=> !busy && !done && overflowCount == '0 &&
    currentSet == '0 && resultBits == '0)
    else $error("outputs not cleared by reset");
  a_start_busy: assert property (
    @(posedge clk) disable iff (!reset_n)
    accept |=> busy [*8])
    else $error("accepted start did not raise busy");
  a_done_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    done |=> !done ##0 !busy)
    else $error("done not a single pulse ending busy");
  a_done_time: assert property (
    @(posedge clk) disable iff (!reset_n)
    done |-> runCnt == 23 * (REGION_WORDS + 1) + 1)
    else $error("done at wrong cycle");
  a_set_word_edge: assert property (
    @(posedge clk) disable iff (!reset_n)
    $changed(currentSet) |-> wordCnt == 1)
    else $error("latch changed inside a word time");
  a_ovf_step: assert property (
    @(posedge clk) disable iff (!reset_n)
    $changed(overflowCount) |->
    overflowCount == $past(overflowCount) + 1'b1 || overflowCount == '0)
    else $error("overflow count jumped");
  a_ovf_at_word: assert property (
    @(posedge clk) disable iff (!reset_n)
    $changed(overflowCount) && overflowCount != '0 |-> wordCnt == 1)
    else $error("overflow counted off a word boundary");
  a_result_gated: assert property (
    @(posedge clk) disable iff (!reset_n)
    resultBits != '0 |-> currentSet[SUB_BUFFER_OUTPUT_OP] ||
    $past(currentSet[SUB_BUFFER_OUTPUT_OP]))
    else $error("result bits without buffer output");
endmodule

bind ais_sequencer ais_sequencer_asserts #(
  .NUM_MODULES(NUM_MODULES), .PROG_DEPTH(PROG_DEPTH),
  .REGION_WORDS(REGION_WORDS), .SELECT_BITS(SELECT_BITS),
  .OVF_COUNT_BITS(OVF_COUNT_BITS)
) i_ais_sequencer_asserts (
  .clk(clk), .reset_n(reset_n), .progWriteEn(progWriteEn),
  .progWriteAddr(progWriteAddr), .progWriteData(progWriteData),
  .progSelect(progSelect), .start(start), .dataInBits(dataInBits),
  .resultBits(resultBits), .busy(busy), .done(done),
  .overflowCount(overflowCount), .currentSet(currentSet)
);

// ===== tb/ais_data_source.sv
`timescale 1ns/100ps
module ais_data_source #(
  parameter int NUM_MODULES = 4
) (
  input wire logic clk,
  input wire logic sync,
  input wire logic [11:0] value,
  output logic [NUM_MODULES-1:0] dataBits
);
  // ------------------------------------------------------------
  // Serial sample feed for every module
  // ------------------------------------------------------------
  int phase = 0;
  // Phase follows the accepted start so bit 0 leads each word time
  always_ff @(posedge clk) begin
    if (sync) begin
      phase <= 0;
    end else begin
      phase <= (phase == 22) ? 0 : phase + 1;
    end
  end
  // Outside the 12 data bits the line shows the inverse of the last bit
  always_comb begin
    if (phase < 12) begin
      dataBits = {NUM_MODULES{value[phase]}};
    end else begin
      dataBits = {NUM_MODULES{~value[11]}};
    end
  end
endmodule

// ===== tb/tb_array_instruction_sequencer.sv
`timescale 1ns/100ps
module tb_array_instruction_sequencer;
  import ais_pkg::*;
  // ------------------------------------------------------------
  // Bench signals and expected decode table
  // ------------------------------------------------------------
  localparam int RW = 4;
  localparam int WT = 23;
  localparam ais_sub_set_t DEC [32] = '{
    1: 23'h11, 2: 23'h22011, 3: 23'h8, 4: 23'h20011, 5: 23'h884,
    6: 23'h1004, 7: 23'h40200, 8: 23'h100004, 9: 23'h184,
    10: 23'h200, 11: 23'h140004, 12: 23'h22, 13: 23'h20042,
    14: 23'h20022, 15: 23'h444, 16: 23'h8004, 17: 23'h4,
    18: 23'h24011, 19: 23'h10800, 20: 23'h10000, 21: 23'h80004,
    22: 23'h44, 23: 23'h50000, 24: 23'h40000, 25: 23'h1000,
    26: 23'h200000, default: 23'h0};
  logic clk, reset_n, progWriteEn, start, busy, done;
  logic [8:0] progWriteAddr;
  logic [2:0] progSelect;
  logic [3:0] dataInBits, resultBits;
  logic [7:0] overflowCount;
  logic [11:0] srcValue, outBits;
  ais_prog_word_t progWriteData;
  ais_sub_set_t currentSet;
  ais_prog_word_t img [32];
  int miscompares, num_checks;

  ais_sequencer #(.REGION_WORDS(RW)) i_ais_sequencer (
    .clk(clk), .reset_n(reset_n), .progWriteEn(progWriteEn),
    .progWriteAddr(progWriteAddr), .progWriteData(progWriteData),
    .progSelect(progSelect), .start(start), .dataInBits(dataInBits),
    .resultBits(resultBits), .busy(busy), .done(done),
    .overflowCount(overflowCount), .currentSet(currentSet));
  ais_data_source #(.NUM_MODULES(4)) i_ais_data_source (
    .clk(clk), .sync(start && !busy), .value(srcValue),
    .dataBits(dataInBits));

  // ------------------------------------------------------------
  // Compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic check_set(input ais_sub_set_t got, input ais_sub_set_t exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: set %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Strobe stays high across back-to-back writes
  task automatic write_word(input int a, input ais_prog_word_t w);
    @(posedge clk);
    #1;
    progWriteEn = 1'b1;
    progWriteAddr = a[8:0];
    progWriteData = w;
    img[a] = w;
  endtask
  // One computation; a poke raises start while busy, which must be ignored
  task automatic run_region(input int sel, input bit poke);
    int a;
    @(posedge clk);
    #1;
    progSelect = sel[2:0];
    start = 1'b1;
    for (int e = 0; e < 300; e++) begin
      @(posedge clk);
      #1;
      start = poke && e == 39;
      if (e == 1) check_num(busy, 1);
      // Module 0 output of the last region word, LSB first
      if (e > WT * RW && e <= WT * RW + 12) begin
        outBits = {resultBits[0], outBits[11:1]};
      end
      if (e % WT == 11 && e > WT && e < WT * (RW + 1)) begin
        a = sel * RW + e / WT - 1;
        check_set(currentSet, DEC[img[a].code] |
          {img[a].bufferOutput, 22'h0});
      end
      if (done === 1'b1) begin
        check_num(e, WT * (RW + 1));
        return;
      end
    end
    miscompares++;
    $display("mismatch at %0t: no done", $time);
    print_verdict();
  endtask

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    progWriteEn = 1'b0;
    progWriteAddr = '0;
    progWriteData = '0;
    progSelect = '0;
    start = 1'b0;
    srcValue = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check_num({busy, done, overflowCount}, 0);
    check_set(currentSet, '0);
    // Every code once, with the buffer-output bit mixed in
    for (int a = 0; a < 32; a++) write_word(a, {a[0] ^ a[3], a[4:0]});
    @(posedge clk);
    #1;
    progWriteEn = 1'b0;
    for (int s = 0; s < 8; s++) run_region(s, s == 2);
    check_num(overflowCount, 0);
    // Load sample, copy it to premultiply, add: one overflow only
    write_word(0, {1'b0, 5'd24});
    write_word(1, {1'b0, 5'd25});
    write_word(2, {1'b0, 5'd17});
    write_word(3, {1'b1, 5'd0});
    // Load, move to intermediate, capture in buffer, shift it out
    write_word(4, {1'b0, 5'd24});
    write_word(5, {1'b0, 5'd10});
    write_word(6, {1'b0, 5'd8});
    write_word(7, {1'b1, 5'd0});
    @(posedge clk);
    #1;
    progWriteEn = 1'b0;
    srcValue = 12'h7ff;
    run_region(0, 1'b0);
    check_num(overflowCount, 1);
    check_num(outBits, 0);
    srcValue = 12'h0a5;
    run_region(1, 1'b0);
    check_num(outBits, 12'h0a5);
    check_num(overflowCount, 0);
    // Reset in mid-run returns the sequencer to idle
    @(posedge clk);
    #1;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    repeat (30) @(posedge clk);
    #1;
    check_num(busy, 1);
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check_num({busy, done, overflowCount}, 0);
    check_set(currentSet, '0);
    run_region(3, 1'b0);
    print_verdict();
  end
endmodule
